/* inc/pwr_seq_params.svh */
// Purpose: Timing and encoding constants for the module power and sleep sequencer
// Assumes: 40 MHz system clock
// Notes:   Times in their own unit; cycle counts derived from them
`ifndef PWR_SEQ_PARAMS_SVH
`define PWR_SEQ_PARAMS_SVH

`define CLK_HZ              40000000
`define IGN_PULSE_MS        2000
`define RST_PULSE_MS        10
`define IGN_PULSE_CYC       ((`IGN_PULSE_MS * 64'd40000000) / 64'd1000)
`define RST_PULSE_CYC       ((`RST_PULSE_MS * 64'd40000000) / 64'd1000)
`define BOOT_MS             3000
`define BOOT_CYC            ((`BOOT_MS * 64'd40000000) / 64'd1000)
`define SLEEP_DLY_MS        100
`define SLEEP_DLY_CYC       ((`SLEEP_DLY_MS * 64'd40000000) / 64'd1000)
`define SLPCFG_TERM_READY   2'h0
`define SLPCFG_AUTO         2'h1
`define SLPCFG_NEVER        2'h2
`define SLPCFG_RSVD         2'h3
`define WAKE_CHAR           8'h00

`endif

/* inc/pwr_seq_pkg.sv */
// Purpose: Types for the module power and sleep sequencer
// Assumes: Nothing
// Notes:   One-hot state codes
package pwr_seq_pkg;

    typedef enum logic [6:0] {
        ST_OFF     = 7'h01,
        ST_IGNITE  = 7'h02,
        ST_BOOT    = 7'h04,
        ST_IDLE    = 7'h08,
        ST_COMM    = 7'h10,
        ST_SLEEP   = 7'h20,
        ST_FLIGHT  = 7'h40
    } pwr_state_e;

endpackage

/* rtl/pwr_seq.sv */
// Function
// R1 - Host holds ignition low 2000 ms after battery present to start module.
// R2 - Host keeps reset released during the whole ignition pulse.
// R3 - Ignition is active low, pulled up; only open-drain drive allowed.
// R4 - Module pulls ignition low itself once ready.
// R5 - Request-to-send goes active some seconds after ignition.
// R6 - I/O supply output off while module off, on in every running mode.
// R7 - Host resets module with a 10 ms low pulse on reset.
// R8 - Reset pulse restarts module at once, no ignition needed.
// R9 - Reset clears processor registers and reinitialises working memory.
// R10 - Reset has no effect before the module has started.
// R11 - Reset is active low with pull-up; open-drain control allowed.
// R12 - Sleep config 1: sleep when no task runs, wake on 0x00 character.
// R13 - Sleep config 0: sleep after terminal-ready goes high, wake when low.
// R14 - Sleep config 2: never enter sleep.
// R15 - Sleep wakes on paging, timer, host character or terminal-ready.
// R16 - No commands accepted in sleep; commands accepted in idle.
// R17 - Flight mode by command: processor active, radio powered down.
// R18 - Communication mode: all subsystems active during a call.
// R19 - Power-off command performs orderly shutdown.
// R20 - Host sends no commands before supply on and request-to-send active.
// R21 - Host times pulses with its own counter, at least stated length.
//
// Purpose: Power-up, reset, power-off and sleep control of a modem module
// Assumes: All inputs synchronous to CLK_SYS_I; ignition pin level seen on input
// Notes:   Long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`include "pwr_seq_params.svh"

module pwr_seq #(
    parameter int unsigned IGN_CYC   = 32'(`IGN_PULSE_CYC),
    parameter int unsigned RST_CYC   = 32'(`RST_PULSE_CYC),
    parameter int unsigned BOOT_CYC  = 32'(`BOOT_CYC),
    parameter int unsigned SLEEP_CYC = 32'(`SLEEP_DLY_CYC)
) (
    input  wire logic       CLK_SYS_I,
    input  wire logic       SRST_I,
    input  wire logic       BATTERY_PRESENT_I,
    input  wire logic       IGNITION_LINE_I,
    output logic            IGNITION_LINE_O,
    output logic            IGNITION_LINE_OE_N_O,
    input  wire logic       RESET_LINE_N_I,
    input  wire logic [1:0] SLEEP_CONFIG_I,
    input  wire logic       SLEEP_CONFIG_WE_I,
    input  wire logic       SERIAL_CHAR_VALID_I,
    input  wire logic [7:0] SERIAL_CHAR_I,
    input  wire logic       SERIAL_TERMINAL_READY_N_I,
    input  wire logic       TASK_BUSY_I,
    input  wire logic       NET_PAGING_I,
    input  wire logic       TIMER_EXPIRED_I,
    input  wire logic       CALL_ACTIVE_I,
    input  wire logic       FLIGHT_CMD_I,
    input  wire logic       FLIGHT_EXIT_CMD_I,
    input  wire logic       POWER_OFF_COMMAND_I,
    output logic            IO_SUPPLY_OUT_O,
    output logic            SERIAL_REQUEST_TO_SEND_OUT_O,
    output logic            CMD_ACCEPT_O,
    output logic            RADIO_ON_O,
    output logic            CPU_ON_O,
    output logic            CPU_CLEAR_O,
    output logic [6:0]      MODE_O
);

    if (IGN_CYC < 1 || RST_CYC < 1 || BOOT_CYC < 1 || SLEEP_CYC < 1)
    begin
        $error("pwr_seq: counts must be at least one cycle");
    end

    // ------------------------------------------------------------
    // Pulse timers
    // ------------------------------------------------------------
    pwr_seq_pkg::pwr_state_e state_q;
    pwr_seq_pkg::pwr_state_e state_d;
    logic [31:0]             ign_cnt_q;
    logic [31:0]             rst_cnt_q;
    logic [31:0]             tmr_q;
    logic [1:0]              slp_cfg_q;
    logic                    ign_done;
    logic                    rst_done;
    logic                    running;
    logic                    wake;

    function automatic logic [31:0] sat_inc(input logic [31:0] v, input logic cond);
        if (!cond)
            sat_inc = 32'h0;
        else if (v != 32'hFFFFFFFF)
            sat_inc = v + 32'h1;
        else
            sat_inc = v;
    endfunction

    function automatic logic is_run(input pwr_seq_pkg::pwr_state_e s);
        is_run = (s == pwr_seq_pkg::ST_IDLE) || (s == pwr_seq_pkg::ST_COMM) ||
                 (s == pwr_seq_pkg::ST_SLEEP) || (s == pwr_seq_pkg::ST_FLIGHT);
    endfunction

    assign running  = is_run(state_q);
    // Ignition only counts while the module itself is not pulling the line
    assign ign_done = (ign_cnt_q >= IGN_CYC);                                    // R1
    assign rst_done = (rst_cnt_q >= RST_CYC);                                    // R7

    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
            ign_cnt_q <= 32'h0;
        else
            ign_cnt_q <= sat_inc(ign_cnt_q, !IGNITION_LINE_I && BATTERY_PRESENT_I &&
                                 RESET_LINE_N_I && !running);                      // R2
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
            rst_cnt_q <= 32'h0;
        else
            rst_cnt_q <= sat_inc(rst_cnt_q, !RESET_LINE_N_I && running);          // R10 R11
    end

    // ------------------------------------------------------------
    // Sleep configuration
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
            slp_cfg_q <= `SLPCFG_NEVER;
        else if (SLEEP_CONFIG_WE_I && state_q != pwr_seq_pkg::ST_SLEEP && SLEEP_CONFIG_I != `SLPCFG_RSVD)
            slp_cfg_q <= SLEEP_CONFIG_I;
    end

    assign wake = NET_PAGING_I || TIMER_EXPIRED_I || !SERIAL_TERMINAL_READY_N_I ||
                  (SERIAL_CHAR_VALID_I && SERIAL_CHAR_I == `WAKE_CHAR);             // R15

    // ------------------------------------------------------------
    // Mode machine
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            pwr_seq_pkg::ST_OFF:
            begin
                if (BATTERY_PRESENT_I && !IGNITION_LINE_I && RESET_LINE_N_I)
                    state_d = pwr_seq_pkg::ST_IGNITE;
            end
            pwr_seq_pkg::ST_IGNITE:
            begin
                if (ign_done)
                    state_d = pwr_seq_pkg::ST_BOOT;                               // R1
                else if (IGNITION_LINE_I || !RESET_LINE_N_I)
                    state_d = pwr_seq_pkg::ST_OFF;                                // R2
            end
            pwr_seq_pkg::ST_BOOT:
            begin
                if (tmr_q >= BOOT_CYC)
                    state_d = pwr_seq_pkg::ST_IDLE;                               // R5
            end
            pwr_seq_pkg::ST_IDLE:
            begin
                if (FLIGHT_CMD_I)
                    state_d = pwr_seq_pkg::ST_FLIGHT;                             // R17
                else if (CALL_ACTIVE_I)
                    state_d = pwr_seq_pkg::ST_COMM;                               // R18
                else if (slp_cfg_q == `SLPCFG_AUTO && !TASK_BUSY_I && !wake)
                    state_d = pwr_seq_pkg::ST_SLEEP;                              // R12
                else if (slp_cfg_q == `SLPCFG_TERM_READY && SERIAL_TERMINAL_READY_N_I &&
                         tmr_q >= SLEEP_CYC)
                    state_d = pwr_seq_pkg::ST_SLEEP;                              // R13
            end
            pwr_seq_pkg::ST_COMM:
            begin
                if (!CALL_ACTIVE_I)
                    state_d = pwr_seq_pkg::ST_IDLE;
            end
            pwr_seq_pkg::ST_SLEEP:
            begin
                if (slp_cfg_q == `SLPCFG_NEVER || wake)
                    state_d = pwr_seq_pkg::ST_IDLE;                               // R14
            end
            pwr_seq_pkg::ST_FLIGHT:
            begin
                if (FLIGHT_EXIT_CMD_I)
                    state_d = pwr_seq_pkg::ST_IDLE;
            end
            default:
                state_d = pwr_seq_pkg::ST_OFF;
        endcase
        if (running && POWER_OFF_COMMAND_I && state_q != pwr_seq_pkg::ST_SLEEP)
            state_d = pwr_seq_pkg::ST_OFF;                                        // R19
        if (rst_done)
            state_d = pwr_seq_pkg::ST_BOOT;                                       // R8
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
            state_q <= pwr_seq_pkg::ST_OFF;
        else
            state_q <= state_d;
    end

    // Boot delay and terminal-ready sleep delay share one timer
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
            tmr_q <= 32'h0;
        else if (state_d != state_q)
            tmr_q <= 32'h0;
        else if (state_q == pwr_seq_pkg::ST_IDLE)
            tmr_q <= sat_inc(tmr_q, SERIAL_TERMINAL_READY_N_I);                   // R13
        else
            tmr_q <= sat_inc(tmr_q, state_q == pwr_seq_pkg::ST_BOOT);
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            IGNITION_LINE_O              <= 1'b0;
            IGNITION_LINE_OE_N_O         <= 1'b1;
            IO_SUPPLY_OUT_O              <= 1'b0;
            SERIAL_REQUEST_TO_SEND_OUT_O <= 1'b0;
            CMD_ACCEPT_O                 <= 1'b0;
            RADIO_ON_O                   <= 1'b0;
            CPU_ON_O                     <= 1'b0;
            CPU_CLEAR_O                  <= 1'b0;
            MODE_O                       <= pwr_seq_pkg::ST_OFF;
        end
        else
        begin
            IGNITION_LINE_O              <= 1'b0;                                 // R3
            IGNITION_LINE_OE_N_O         <= !is_run(state_d);                     // R4
            IO_SUPPLY_OUT_O              <= state_d != pwr_seq_pkg::ST_OFF &&
                                            state_d != pwr_seq_pkg::ST_IGNITE;    // R6
            SERIAL_REQUEST_TO_SEND_OUT_O <= state_d == pwr_seq_pkg::ST_IDLE ||
                                            state_d == pwr_seq_pkg::ST_COMM ||
                                            state_d == pwr_seq_pkg::ST_FLIGHT;    // R5
            CMD_ACCEPT_O                 <= state_d == pwr_seq_pkg::ST_IDLE ||
                                            state_d == pwr_seq_pkg::ST_COMM ||
                                            state_d == pwr_seq_pkg::ST_FLIGHT;    // R16
            RADIO_ON_O                   <= state_d == pwr_seq_pkg::ST_IDLE ||
                                            state_d == pwr_seq_pkg::ST_COMM ||
                                            state_d == pwr_seq_pkg::ST_SLEEP;     // R17
            CPU_ON_O                     <= state_d != pwr_seq_pkg::ST_OFF &&
                                            state_d != pwr_seq_pkg::ST_IGNITE;    // R18
            CPU_CLEAR_O                  <= rst_done;                             // R9
            MODE_O                       <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_supply_off;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (state_q == pwr_seq_pkg::ST_OFF) |-> ##1 !IO_SUPPLY_OUT_O || state_q != pwr_seq_pkg::ST_OFF;
    endproperty
    a_supply_off: assert property (p_supply_off) else $error("Supply on while off"); // R6

    property p_no_cmd_sleep;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (state_q == pwr_seq_pkg::ST_SLEEP) |-> !CMD_ACCEPT_O;
    endproperty
    a_no_cmd_sleep: assert property (p_no_cmd_sleep) else $error("Command accepted in sleep"); // R16

    property p_never_sleep;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (slp_cfg_q == `SLPCFG_NEVER && state_q == pwr_seq_pkg::ST_IDLE) |=> state_q != pwr_seq_pkg::ST_SLEEP;
    endproperty
    a_never_sleep: assert property (p_never_sleep) else $error("Slept with sleep disabled"); // R14

    property p_reset_restart;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        $rose(rst_done) |=> state_q == pwr_seq_pkg::ST_BOOT && CPU_CLEAR_O;
    endproperty
    a_reset_restart: assert property (p_reset_restart) else $error("Reset did not restart"); // R8

    property p_reset_ignored_off;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (state_q == pwr_seq_pkg::ST_OFF) |-> rst_cnt_q == 32'h0;
    endproperty
    a_reset_ignored_off: assert property (p_reset_ignored_off) else $error("Reset acted while off"); // R10

    property p_flight_radio;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (state_q == pwr_seq_pkg::ST_FLIGHT) |-> ##1 (!RADIO_ON_O && CPU_ON_O) || state_q != pwr_seq_pkg::ST_FLIGHT;
    endproperty
    a_flight_radio: assert property (p_flight_radio) else $error("Flight mode radio state wrong"); // R17

    property p_wake_char;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (state_q == pwr_seq_pkg::ST_SLEEP && SERIAL_CHAR_VALID_I && SERIAL_CHAR_I == `WAKE_CHAR
         && !rst_done) |=> state_q == pwr_seq_pkg::ST_IDLE;
    endproperty
    a_wake_char: assert property (p_wake_char) else $error("No wake on null character"); // R12

    property p_ready_pull;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        running |-> !IGNITION_LINE_OE_N_O && !IGNITION_LINE_O;
    endproperty
    a_ready_pull: assert property (p_ready_pull) else $error("Ignition not pulled when ready"); // R4

    property p_power_off;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (state_q == pwr_seq_pkg::ST_IDLE && POWER_OFF_COMMAND_I && !rst_done) |=> state_q == pwr_seq_pkg::ST_OFF;
    endproperty
    a_power_off: assert property (p_power_off) else $error("Power-off command ignored"); // R19

    property p_rts_ready;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (state_q == pwr_seq_pkg::ST_IDLE) |-> SERIAL_REQUEST_TO_SEND_OUT_O;
    endproperty
    a_rts_ready: assert property (p_rts_ready) else $error("Request-to-send low in idle"); // R5

    property p_supply_on;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        running |-> IO_SUPPLY_OUT_O;
    endproperty
    a_supply_on: assert property (p_supply_on) else $error("Supply off while running"); // R6

    property p_clear_boot;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        CPU_CLEAR_O |-> state_q == pwr_seq_pkg::ST_BOOT;
    endproperty
    a_clear_boot: assert property (p_clear_boot) else $error("Clear outside restart"); // R9

    property p_term_wake;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (state_q == pwr_seq_pkg::ST_SLEEP && !SERIAL_TERMINAL_READY_N_I && !rst_done) |=> state_q == pwr_seq_pkg::ST_IDLE;
    endproperty
    a_term_wake: assert property (p_term_wake) else $error("No wake on terminal-ready"); // R13

    property p_event_wake;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (state_q == pwr_seq_pkg::ST_SLEEP && (NET_PAGING_I || TIMER_EXPIRED_I) && !rst_done)
         |=> state_q == pwr_seq_pkg::ST_IDLE;
    endproperty
    a_event_wake: assert property (p_event_wake) else $error("No wake on paging or timer"); // R15

    property p_comm_on;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (state_q == pwr_seq_pkg::ST_COMM) |-> RADIO_ON_O && CPU_ON_O && IO_SUPPLY_OUT_O;
    endproperty
    a_comm_on: assert property (p_comm_on) else $error("Subsystem off during call"); // R18

    property p_ignite_abort;
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (state_q == pwr_seq_pkg::ST_IGNITE && IGNITION_LINE_I && !ign_done) |=> state_q == pwr_seq_pkg::ST_OFF;
    endproperty
    a_ignite_abort: assert property (p_ignite_abort) else $error("Short ignition not refused"); // R1

endmodule

/* verification/pwr_host_model.sv */
// Purpose: Host side pulsing the ignition and reset lines
// Assumes: Pulse lengths given in system clock cycles
// Notes:   Open-drain pulls only; both wires resolved with pull-ups
`timescale 1ns/1ps
module pwr_host_model (
    input  wire logic        clk_i,
    input  wire logic        ign_go_i,
    input  wire logic        rst_go_i,
    input  wire logic [15:0] len_i,
    input  wire logic        mod_ign_o_i,
    input  wire logic        mod_ign_oe_n_i,
    output logic             ign_wire_o,
    output logic             rst_n_wire_o
);
    logic [15:0] ign_cnt_q = 16'h0;
    logic [15:0] rst_cnt_q = 16'h0;

    // Pulse timers on the host clock
    always_ff @(posedge clk_i)
    begin
        if (ign_go_i && rst_cnt_q == 16'h0)
            ign_cnt_q <= len_i;
        else if (ign_cnt_q != 16'h0)
            ign_cnt_q <= ign_cnt_q - 16'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_go_i && ign_cnt_q == 16'h0)
            rst_cnt_q <= len_i;
        else if (rst_cnt_q != 16'h0)
            rst_cnt_q <= rst_cnt_q - 16'h1;
    end

    // Nobody drives high; pull-ups give the idle level
    assign ign_wire_o = (ign_cnt_q != 16'h0 || (!mod_ign_oe_n_i && !mod_ign_o_i)) ? 1'b0 : 1'b1;
    assign rst_n_wire_o = (rst_cnt_q != 16'h0) ? 1'b0 : 1'b1;
endmodule

/* verification/pwr_seq_tb_top.sv */
// Purpose: Self-checking bench for the power and sleep sequencer
// Assumes: Shortened counts 20, 5, 10, 8 cycles
// Notes:   Expected modes queued by the driver, popped on each mode change
`timescale 1ns/1ps
module pwr_seq_tb_top;
    localparam int unsigned IGN = 20, RST = 5, BOOT = 10, SLP = 8;
    logic        clk, srst, bat, ign_w, ign_o, ign_oe_n, rst_w, cfg_we, chv, term_n, busy;
    logic        page, tmr, call, fl, flx, poff, io, rts, acc, radio, cpu, clr, ign_go, rst_go, seen;
    logic [1:0]  cfg;
    logic [7:0]  chr;
    logic [6:0]  mode;
    logic [6:0]  last_mode = 7'h01;
    logic [15:0] len;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          seed = 80168;
    int          ev;
    logic [6:0]  expq[$];

    pwr_seq #(.IGN_CYC(IGN), .RST_CYC(RST), .BOOT_CYC(BOOT), .SLEEP_CYC(SLP)) uut (
        .CLK_SYS_I(clk), .SRST_I(srst), .BATTERY_PRESENT_I(bat), .IGNITION_LINE_I(ign_w),
        .IGNITION_LINE_O(ign_o), .IGNITION_LINE_OE_N_O(ign_oe_n), .RESET_LINE_N_I(rst_w),
        .SLEEP_CONFIG_I(cfg), .SLEEP_CONFIG_WE_I(cfg_we), .SERIAL_CHAR_VALID_I(chv),
        .SERIAL_CHAR_I(chr), .SERIAL_TERMINAL_READY_N_I(term_n), .TASK_BUSY_I(busy),
        .NET_PAGING_I(page), .TIMER_EXPIRED_I(tmr), .CALL_ACTIVE_I(call), .FLIGHT_CMD_I(fl),
        .FLIGHT_EXIT_CMD_I(flx), .POWER_OFF_COMMAND_I(poff), .IO_SUPPLY_OUT_O(io),
        .SERIAL_REQUEST_TO_SEND_OUT_O(rts), .CMD_ACCEPT_O(acc), .RADIO_ON_O(radio),
        .CPU_ON_O(cpu), .CPU_CLEAR_O(clr), .MODE_O(mode));

    pwr_host_model host (.clk_i(clk), .ign_go_i(ign_go), .rst_go_i(rst_go), .len_i(len),
        .mod_ign_o_i(ign_o), .mod_ign_oe_n_i(ign_oe_n), .ign_wire_o(ign_w), .rst_n_wire_o(rst_w));

    // ------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------
    // Per mode: {io, rts, acc, radio, cpu, oe_n} value and care mask
    function automatic logic [11:0] exp_outs(input logic [6:0] m);
        case (m)
            7'h01: return {6'h01, 6'h3F};
            7'h02: return {6'h01, 6'h39};
            7'h04: return {6'h21, 6'h39};
            7'h08: return {6'h3E, 6'h3F};
            7'h10: return {6'h26, 6'h27};
            7'h20: return {6'h20, 6'h29};
            7'h40: return {6'h22, 6'h27};
            default: return 12'h000;
        endcase
    endfunction

    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic check_mode(input logic [6:0] got, input logic [6:0] exp);
        logic [11:0] e;
        e = exp_outs(exp);
        check_count++;
        if (got !== exp || (({io, rts, acc, radio, cpu, ign_oe_n} ^ e[11:6]) & e[5:0]) !== 6'h00)
        begin
            n_mismatch++;
            $display("ERROR %0t mode %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(negedge clk)
    begin
        if (!srst && mode !== last_mode)
        begin
            if (expq.size() == 0)
                check_bit(1'b0, 1'b1);
            else
                check_mode(mode, expq.pop_front());
        end
        last_mode <= mode;
    end

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            $display("ERROR %0t timeout", $time);
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic cmd(input int k);
        @(posedge clk);
        case (k)
            0: fl <= 1'b1;
            1: flx <= 1'b1;
            2: poff <= 1'b1;
            3: page <= 1'b1;
            4: tmr <= 1'b1;
            5: {chv, chr} <= 9'h100;
            6: ign_go <= 1'b1;
            7: rst_go <= 1'b1;
            8: term_n <= 1'b0;
            10: chv <= 1'b1;
            default: cfg_we <= 1'b1;
        endcase
        @(posedge clk);
        {fl, flx, poff, page, tmr, chv, ign_go, rst_go, cfg_we} <= 9'h000;
        chr <= 8'($random(seed)) | 8'h01;
    endtask

    task automatic wait_for(input logic [6:0] m);
        int i;
        for (i = 0; i < 200 && mode !== m; i++)
            @(negedge clk);
        check_bit(mode === m, 1'b1);
        @(posedge clk);
    endtask

    task automatic ignite();
        len <= 16'(IGN + 2 + (unsigned'($random(seed)) % 4));
        expq.push_back(7'h02);
        expq.push_back(7'h04);
        expq.push_back(7'h08);
        cmd(6);
        wait_for(7'h08);
        @(negedge clk);
        check_bit(io & rts, 1'b1);
        check_bit(ign_w, 1'b0);
        @(posedge clk);
    endtask

    initial
    begin
        {srst, bat, busy} = 3'h7;
        {cfg_we, chv, term_n, page, tmr, call, fl, flx, poff, ign_go, rst_go} = 11'h000;
        cfg = 2'h0;
        chr = 8'h00;
        len = 16'h0000;
        // Noise on the inputs that reset must mask
        repeat (15)
        begin
            @(posedge clk);
            {fl, flx, poff, page, tmr, chv, call, cfg_we, term_n, cfg, chr} <= 19'($random(seed));
        end
        @(posedge clk);
        srst <= 1'b0;
        {fl, flx, poff, page, tmr, chv, call, cfg_we, term_n} <= 9'h000;
        len <= 16'(RST + 3);
        @(negedge clk);
        check_mode(mode, 7'h01);
        cmd(7);
        step(20);
        check_bit(mode === 7'h01, 1'b1);
        bat <= 1'b0;
        len <= 16'h000A;
        cmd(6);
        step(15);
        check_bit(mode === 7'h01, 1'b1);
        bat <= 1'b1;
        expq.push_back(7'h02);
        expq.push_back(7'h01);
        cmd(6);
        wait_for(7'h02);
        wait_for(7'h01);
        ignite();
        expq.push_back(7'h40);
        cmd(0);
        wait_for(7'h40);
        expq.push_back(7'h08);
        cmd(1);
        wait_for(7'h08);
        call <= 1'b1;
        expq.push_back(7'h10);
        wait_for(7'h10);
        expq.push_back(7'h01);
        cmd(2);
        wait_for(7'h01);
        call <= 1'b0;
        ignite();
        cfg <= 2'h2;
        cmd(9);
        {busy, term_n} <= {1'($random(seed)), 1'b1};
        step(3 * SLP);
        check_bit(mode === 7'h08, 1'b1);
        term_n <= 1'b0;
        cfg <= 2'h0;
        cmd(9);
        term_n <= 1'b1;
        expq.push_back(7'h20);
        step(SLP - 2);
        check_bit(mode === 7'h08, 1'b1);
        wait_for(7'h20);
        expq.push_back(7'h08);
        term_n <= 1'b0;
        wait_for(7'h08);
        {busy, term_n, cfg} <= 4'hD;
        cmd(9);
        for (int k = 0; k < 6; k++)
        begin
            ev = int'(unsigned'($random(seed)) % 4);
            busy <= 1'b0;
            expq.push_back(7'h20);
            wait_for(7'h20);
            if (k == 0)
            begin
                cmd(2);
                cfg <= 2'h2;
                cmd(9);
                cmd(10);
                step(4);
                check_bit(mode === 7'h20, 1'b1);
                cfg <= 2'h1;
            end
            expq.push_back(7'h08);
            cmd((ev == 3) ? 8 : ev + 3);
            {busy, term_n} <= 2'h3;
            wait_for(7'h08);
            step(int'(unsigned'($random(seed)) % 5) + 1);
        end
        expq.push_back(7'h04);
        expq.push_back(7'h08);
        len <= 16'(RST + 3 + (unsigned'($random(seed)) % 4));
        cmd(7);
        wait_for(7'h04);
        seen = 1'b0;
        repeat (3)
        begin
            @(negedge clk);
            seen = seen | clr;
        end
        check_bit(seen, 1'b1);
        wait_for(7'h08);
        expq.push_back(7'h01);
        cmd(2);
        wait_for(7'h01);
        step(5);
        check_bit(expq.size() == 0, 1'b1);
        end_of_test();
    end
endmodule
